//--- common/mcp_pkg.sv
// package for the serial channel modem-control pin block
package mcp_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_RX_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;
	localparam logic [7:0] ADDR_TX_CTRL = 8'h08;
	localparam logic [7:0] ADDR_EXT_FEAT = 8'h0c;
	localparam logic [7:0] ADDR_MISC_CTRL = 8'h10;
	localparam logic [7:0] ADDR_MAIN_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int RXC_AUTO_EN = 5;
	localparam int MODE_CLK_LO = 6;
	localparam int MODE_SYNC_LO = 4;
	localparam int MODE_STOP_LO = 2;
	localparam int TXC_RTS = 1;
	localparam int TXC_DTR = 7;
	localparam int EXT_RTS_SDLC = 2;
	localparam int EXT_DTR_FAST = 4;
	localparam int MISC_DTR_REQ = 2;
	localparam int MISC_XTAL = 0;
	localparam int MISC_WREQ_REQ = 1;
	localparam int ST_DCD = 3;
	localparam int ST_SYNC = 4;
	localparam int ST_CTS = 5;
	localparam int ST_TX_EMPTY = 2;

	// irq status bits
	localparam int IRQ_CTS = 2;
	localparam int IRQ_DCD = 1;
	localparam int IRQ_SYNC = 0;
	localparam int IRQ_W = 3;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [3:0] RST_MASK = 4'h0;
	localparam logic [2:0] DTR_SLOW_CYCLES = 3'h4;

	// sync mode field encodings
	localparam logic [1:0] SYNC_MONO = 2'h0;
	localparam logic [1:0] SYNC_BI = 2'h1;
	localparam logic [1:0] SYNC_SDLC = 2'h2;
	localparam logic [1:0] SYNC_EXT = 2'h3;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic cts_n;
		logic dcd_n;
		logic sync_n;
	} mcp_modem_in_t;

	typedef struct packed {
		logic tx_empty;
		logic flag_sent;
		logic sync_match;
		logic flag_rcvd;
		logic tx_dma_req;
		logic rx_dma_req;
	} mcp_core_t;

	typedef enum logic [1:0] {
		DTR_IDLE = 2'b00,
		DTR_ACTIVE = 2'b01,
		DTR_HOLD = 2'b10
	} mcp_dtr_state_t;

endpackage

//--- hw/mcp_top.sv
// modem-control, sync, request and clock pin logic of one serial channel
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module mcp_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire mcp_pkg::mcp_modem_in_t modem_in,
	input wire mcp_pkg::mcp_core_t core,
	input wire logic rx_tx_clock_in_n,
	input wire logic tx_rx_clock_in_n,
	input wire logic [3:0] clk_sources,
	output logic rts_n,
	output logic dtr_req_n,
	output logic sync_out_n,
	output logic sync_oe,
	output logic wait_req_out,
	output logic wait_req_oe,
	output logic tx_enable,
	output logic rx_enable,
	output logic rx_assembly_start,
	output logic [1:0] rx_clk_sel,
	output logic rx_clk_ff,
	output logic [6:0] rx_clk_div,
	output logic tx_rx_clock_out_n,
	output logic tx_rx_clock_oe
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] rx_control_reg_ff;
	logic [7:0] mode_control_reg_ff;
	logic [7:0] tx_control_reg_ff;
	logic [7:0] extended_feature_reg_ff;
	logic [7:0] misc_control_reg_ff;
	logic [3:0] irq_status_ff;
	logic [3:0] irq_mask_ff;
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic [2:0] prev_ff;
	logic rts_ff;
	logic rxc_prev_ff;
	logic ext_sync_seen_ff;
	logic [2:0] dtr_cnt_ff;
	mcp_pkg::mcp_dtr_state_t dtr_state_ff;
	mcp_pkg::mcp_dtr_state_t nxt_dtr_state;
	logic [2:0] nxt_dtr_cnt;

	logic wr_en;
	logic rd_en;
	logic auto_en;
	logic async_mode;
	logic sync_modes;
	logic xtal;
	logic [1:0] sync_kind;
	logic [2:0] edge_ev;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	logic [31:0] nxt_rdata;
	logic cts_s;
	logic dcd_s;
	logic sync_s;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign auto_en = rx_control_reg_ff[mcp_pkg::RXC_AUTO_EN];
	assign async_mode = mode_control_reg_ff[mcp_pkg::MODE_STOP_LO +: 2] != 2'h0;
	assign sync_modes = !async_mode;
	assign sync_kind = mode_control_reg_ff[mcp_pkg::MODE_SYNC_LO +: 2];
	assign xtal = misc_control_reg_ff[mcp_pkg::MISC_XTAL];
	assign cts_s = sync2_ff[2];
	assign dcd_s = sync2_ff[1];
	assign sync_s = sync2_ff[0];

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_control_reg_ff <= mcp_pkg::RST_CTRL;
			mode_control_reg_ff <= mcp_pkg::RST_CTRL;
			tx_control_reg_ff <= mcp_pkg::RST_CTRL;
			extended_feature_reg_ff <= mcp_pkg::RST_CTRL;
			misc_control_reg_ff <= mcp_pkg::RST_CTRL;
			irq_mask_ff <= mcp_pkg::RST_MASK;
		end else if (wr_en) begin
			case (paddr)
				mcp_pkg::ADDR_RX_CTRL: begin
					rx_control_reg_ff <= pwdata[7:0];
				end
				mcp_pkg::ADDR_MODE_CTRL: begin
					mode_control_reg_ff <= pwdata[7:0];
				end
				mcp_pkg::ADDR_TX_CTRL: begin
					tx_control_reg_ff <= pwdata[7:0];
				end
				mcp_pkg::ADDR_EXT_FEAT: begin
					extended_feature_reg_ff <= pwdata[7:0];
				end
				mcp_pkg::ADDR_MISC_CTRL: begin
					misc_control_reg_ff <= pwdata[7:0];
				end
				mcp_pkg::ADDR_IRQ_MASK: begin
					irq_mask_ff <= pwdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (paddr)
			mcp_pkg::ADDR_RX_CTRL: nxt_rdata[7:0] = rx_control_reg_ff;
			mcp_pkg::ADDR_MODE_CTRL: nxt_rdata[7:0] = mode_control_reg_ff;
			mcp_pkg::ADDR_TX_CTRL: nxt_rdata[7:0] = tx_control_reg_ff;
			mcp_pkg::ADDR_EXT_FEAT: nxt_rdata[7:0] = extended_feature_reg_ff;
			mcp_pkg::ADDR_MISC_CTRL: nxt_rdata[7:0] = misc_control_reg_ff;
			mcp_pkg::ADDR_MAIN_STATUS: begin
				nxt_rdata[mcp_pkg::ST_CTS] = !cts_s;
				nxt_rdata[mcp_pkg::ST_DCD] = !dcd_s;
				nxt_rdata[mcp_pkg::ST_SYNC] = !sync_s;
				nxt_rdata[mcp_pkg::ST_TX_EMPTY] = core.tx_empty;
			end
			mcp_pkg::ADDR_IRQ_STATUS: nxt_rdata[3:0] = irq_status_ff;
			mcp_pkg::ADDR_IRQ_MASK: nxt_rdata[3:0] = irq_mask_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && paddr > mcp_pkg::ADDR_IRQ_MASK;
			prdata <= (rd_en && !pready) ? nxt_rdata : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// input synchronisers and edge detect
	// ------------------------------------------------------------
	// two-stage synchroniser
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_ff <= 3'h7;
			sync2_ff <= 3'h7;
			prev_ff <= 3'h7;
		end else begin
			sync1_ff <= {modem_in.cts_n, modem_in.dcd_n, modem_in.sync_n};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// both edges on every modem input
	generate
		for (genvar i = 0; i < 3; i++) begin : g_edge
			assign edge_ev[i] = sync2_ff[i] ^ prev_ff[i];
		end
	endgenerate

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	// sync input edges only touch status, only in async without crystal
	always_comb begin
		irq_set = 4'h0;
		irq_set[mcp_pkg::IRQ_CTS] = edge_ev[2];
		irq_set[mcp_pkg::IRQ_DCD] = edge_ev[1];
		irq_set[mcp_pkg::IRQ_SYNC] = edge_ev[0] && async_mode && !xtal;
		irq_set[mcp_pkg::IRQ_W] = core.tx_dma_req && !misc_control_reg_ff[mcp_pkg::MISC_WREQ_REQ];
	end
	assign irq_clr = (wr_en && paddr == mcp_pkg::ADDR_IRQ_STATUS) ? pwdata[3:0] : 4'h0;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_status_ff <= 4'h0;
			irq <= 1'b0;
		end else begin
			irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
			irq <= |(((irq_status_ff & ~irq_clr) | irq_set) & irq_mask_ff);
		end
	end

	// ------------------------------------------------------------
	// transmitter/receiver enables and request-to-send
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_enable <= 1'b1;
			rx_enable <= 1'b1;
			rts_ff <= 1'b0;
			rts_n <= 1'b1;
		end else begin
			tx_enable <= !auto_en || !cts_s;
			rx_enable <= !auto_en || !dcd_s;
			if (tx_control_reg_ff[mcp_pkg::TXC_RTS]) begin
				rts_ff <= 1'b1;
			end else if (auto_en && async_mode) begin
				if (core.tx_empty) begin
					rts_ff <= 1'b0;
				end
			end else if (sync_modes && sync_kind == mcp_pkg::SYNC_SDLC
				&& extended_feature_reg_ff[mcp_pkg::EXT_RTS_SDLC]) begin
				// drop after closing flag has left the pin
				if (core.flag_sent) begin
					rts_ff <= 1'b0;
				end
			end else begin
				// plain inverse of the control bit
				rts_ff <= 1'b0;
			end
			rts_n <= !(tx_control_reg_ff[mcp_pkg::TXC_RTS] || rts_ff);
		end
	end

	// ------------------------------------------------------------
	// sync pin
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_oe <= 1'b0;
			sync_out_n <= 1'b1;
			rx_assembly_start <= 1'b0;
			ext_sync_seen_ff <= 1'b0;
		end else begin
			// output in internal sync and sdlc modes without crystal
			sync_oe <= sync_modes && !xtal && sync_kind != mcp_pkg::SYNC_EXT;
			case (sync_kind)
				mcp_pkg::SYNC_MONO, mcp_pkg::SYNC_BI: sync_out_n <= !core.sync_match;
				mcp_pkg::SYNC_SDLC: sync_out_n <= !core.flag_rcvd;
				default: sync_out_n <= 1'b1;
			endcase
			// assembly starts on first low of external sync
			rx_assembly_start <= sync_modes && sync_kind == mcp_pkg::SYNC_EXT
				&& !sync_s && !ext_sync_seen_ff;
			ext_sync_seen_ff <= sync_modes && sync_kind == mcp_pkg::SYNC_EXT && !sync_s;
		end
	end

	// ------------------------------------------------------------
	// terminal-ready / dma request
	// ------------------------------------------------------------
	// fast or four-clock deactivation
	always_comb begin
		nxt_dtr_state = dtr_state_ff;
		nxt_dtr_cnt = dtr_cnt_ff;
		case (dtr_state_ff)
			mcp_pkg::DTR_IDLE: begin
				if (core.tx_dma_req) begin
					nxt_dtr_state = mcp_pkg::DTR_ACTIVE;
				end
			end
			mcp_pkg::DTR_ACTIVE: begin
				if (!core.tx_dma_req) begin
					if (extended_feature_reg_ff[mcp_pkg::EXT_DTR_FAST]) begin
						nxt_dtr_state = mcp_pkg::DTR_IDLE;
					end else begin
						nxt_dtr_state = mcp_pkg::DTR_HOLD;
						nxt_dtr_cnt = mcp_pkg::DTR_SLOW_CYCLES - 3'h2;
					end
				end
			end
			mcp_pkg::DTR_HOLD: begin
				if (dtr_cnt_ff == 3'h0) begin
					nxt_dtr_state = mcp_pkg::DTR_IDLE;
				end else begin
					nxt_dtr_cnt = dtr_cnt_ff - 3'h1;
				end
			end
			default: nxt_dtr_state = mcp_pkg::DTR_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dtr_state_ff <= mcp_pkg::DTR_IDLE;
			dtr_cnt_ff <= 3'h0;
			dtr_req_n <= 1'b1;
		end else begin
			dtr_state_ff <= nxt_dtr_state;
			dtr_cnt_ff <= nxt_dtr_cnt;
			// select terminal-ready bit or dma request
			if (misc_control_reg_ff[mcp_pkg::MISC_DTR_REQ]) begin
				dtr_req_n <= nxt_dtr_state == mcp_pkg::DTR_IDLE;
			end else begin
				dtr_req_n <= !tx_control_reg_ff[mcp_pkg::TXC_DTR];
			end
		end
	end

	// ------------------------------------------------------------
	// wait/request pin
	// ------------------------------------------------------------
	// open-drain wait after reset, driven in request mode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wait_req_out <= 1'b0;
			wait_req_oe <= 1'b0;
		end else if (misc_control_reg_ff[mcp_pkg::MISC_WREQ_REQ]) begin
			wait_req_out <= !(core.tx_dma_req || core.rx_dma_req);
			wait_req_oe <= 1'b1;
		end else begin
			wait_req_out <= 1'b0;
			wait_req_oe <= core.tx_dma_req && !core.tx_empty;
		end
	end

	// ------------------------------------------------------------
	// clock pins
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_clk_div <= 7'h01;
			rx_clk_sel <= 2'h0;
			rx_clk_ff <= 1'b0;
			rxc_prev_ff <= 1'b1;
			tx_rx_clock_out_n <= 1'b1;
			tx_rx_clock_oe <= 1'b0;
		end else begin
			case (mode_control_reg_ff[mcp_pkg::MODE_CLK_LO +: 2])
				2'h0: rx_clk_div <= 7'h01;
				2'h1: rx_clk_div <= 7'h10;
				2'h2: rx_clk_div <= 7'h20;
				default: rx_clk_div <= 7'h40;
			endcase
			// receive/transmit clock input use, crystal when selected
			rx_clk_sel <= misc_control_reg_ff[5:4];
			rxc_prev_ff <= rx_tx_clock_in_n;
			rx_clk_ff <= xtal ? clk_sources[1] : !rx_tx_clock_in_n;
			// transmit/receive clock pin as input or driven source
			tx_rx_clock_oe <= misc_control_reg_ff[6];
			tx_rx_clock_out_n <= misc_control_reg_ff[6] ? !clk_sources[misc_control_reg_ff[4:3]]
				: tx_rx_clock_in_n;
		end
	end

endmodule

//--- sim/mcp_sva.sv
// assertions on the ports of the modem-control pin block
`timescale 1ns/1ps
module mcp_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire mcp_pkg::mcp_modem_in_t modem_in,
	input wire mcp_pkg::mcp_core_t core,
	input wire logic rts_n,
	input wire logic dtr_req_n,
	input wire logic wait_req_oe,
	input wire logic tx_enable,
	input wire logic rx_enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic auto_ff, rts_ff, dtr_ff, dreq_ff, fast_ff;
	// ------------------------------------------------------------
	// shadow of written control bits
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			auto_ff <= 1'b0;
			rts_ff <= 1'b0;
			dtr_ff <= 1'b0;
			dreq_ff <= 1'b0;
			fast_ff <= 1'b0;
		end else if (psel && penable && pwrite && pready) begin
			if (paddr == mcp_pkg::ADDR_RX_CTRL) auto_ff <= pwdata[mcp_pkg::RXC_AUTO_EN];
			if (paddr == mcp_pkg::ADDR_TX_CTRL) rts_ff <= pwdata[mcp_pkg::TXC_RTS];
			if (paddr == mcp_pkg::ADDR_TX_CTRL) dtr_ff <= pwdata[mcp_pkg::TXC_DTR];
			if (paddr == mcp_pkg::ADDR_MISC_CTRL) dreq_ff <= pwdata[mcp_pkg::MISC_DTR_REQ];
			if (paddr == mcp_pkg::ADDR_EXT_FEAT) fast_ff <= pwdata[mcp_pkg::EXT_DTR_FAST];
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_pready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_tx_free_run: assert property ((!auto_ff || !modem_in.cts_n)[*5] |-> tx_enable)
		else $error("transmitter not enabled");
	a_cts_gates_tx: assert property ((auto_ff && modem_in.cts_n)[*5] |-> !tx_enable)
		else $error("transmitter enabled without clear-to-send");
	a_dcd_gates_rx: assert property ((auto_ff && modem_in.dcd_n)[*5] |-> !rx_enable)
		else $error("receiver enabled without carrier");
	a_rts_follows_bit: assert property ((!auto_ff && $stable(rts_ff))[*3] |-> rts_n == !rts_ff)
		else $error("rts pin not inverse of bit");
	a_dtr_follows_bit: assert property ((!dreq_ff && $stable(dtr_ff))[*3] |-> dtr_req_n == !dtr_ff)
		else $error("dtr pin not inverse of bit");
	a_dtr_slow_release: assert property (dreq_ff && !fast_ff && $fell(core.tx_dma_req) |=> !dtr_req_n ##[1:6] dtr_req_n)
		else $error("slow request release wrong");
	a_dtr_fast_release: assert property (dreq_ff && fast_ff && $fell(core.tx_dma_req) |-> ##[1:3] dtr_req_n)
		else $error("fast request release late");
	a_reset_idle_pins: assert property (disable iff (1'b0) $fell(rst) |-> !wait_req_oe && !irq && rts_n && dtr_req_n)
		else $error("pins not idle after reset");
	c_auto_gate: cover property ((auto_ff && modem_in.cts_n)[*5]);
	c_irq_seen: cover property ($rose(irq));
	c_dma_release: cover property (dreq_ff && $fell(core.tx_dma_req));
endmodule

//--- sim/mcp_line_model.sv
// modem line levels and dma controller facing one channel
`timescale 1ns/1ps
module mcp_line_model (
	input wire logic sys_clk,
	input wire logic [2:0] lvl_n,
	input wire logic dma_on,
	input wire logic slow,
	input wire logic dtr_req_n,
	input wire logic [4:0] core_lvl,
	output mcp_pkg::mcp_modem_in_t modem_in,
	output mcp_pkg::mcp_core_t core
);
	logic [2:0] wait_ff;
	initial begin
		modem_in = '1;
		core = '0;
		wait_ff = 3'h0;
	end
	// modem levels change just after an edge
	always @(posedge sys_clk) begin
		modem_in <= mcp_pkg::mcp_modem_in_t'(lvl_n);
		{core.tx_empty, core.flag_sent, core.sync_match, core.flag_rcvd, core.rx_dma_req} <= core_lvl;
	end
	// transmitter asks once; dma serves after the pin stands low a while
	always @(posedge sys_clk) begin
		if (!dma_on) begin
			core.tx_dma_req <= 1'b0;
			wait_ff <= 3'h0;
		end else if (wait_ff == 3'h0) begin
			core.tx_dma_req <= 1'b1;
			wait_ff <= 3'h1;
		end else if (wait_ff == (slow ? 3'h6 : 3'h2)) begin
			core.tx_dma_req <= 1'b0;
		end else if (!dtr_req_n) begin
			wait_ff <= wait_ff + 3'h1;
		end
	end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the modem-control pin block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_top;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
	logic rts_n, dtr_req_n, sync_oe, wait_req_oe, tx_enable, rx_enable, dma_on, slow;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] lvl_n;
	logic e;
	logic sync_out_n, wait_req_out, rx_assembly_start, rx_clk_ff, tx_rx_clock_out_n, tx_rx_clock_oe;
	logic rx_tx_clk_n, tx_rx_clk_n;
	logic [1:0] rx_clk_sel;
	logic [6:0] rx_clk_div;
	logic [4:0] core_lvl;
	logic [3:0] clk_src;
	mcp_pkg::mcp_modem_in_t modem_in;
	mcp_pkg::mcp_core_t core;
	int err_total, checks_done;
	always #10 sys_clk = ~sys_clk;
	mcp_line_model u_line (.sys_clk(sys_clk), .lvl_n(lvl_n), .dma_on(dma_on), .slow(slow),
		.dtr_req_n(dtr_req_n), .core_lvl(core_lvl), .modem_in(modem_in), .core(core));
	mcp_top u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.modem_in(modem_in), .core(core), .rx_tx_clock_in_n(rx_tx_clk_n), .tx_rx_clock_in_n(tx_rx_clk_n),
		.clk_sources(clk_src), .rts_n(rts_n), .dtr_req_n(dtr_req_n), .sync_out_n(sync_out_n),
		.sync_oe(sync_oe), .wait_req_out(wait_req_out), .wait_req_oe(wait_req_oe), .tx_enable(tx_enable),
		.rx_enable(rx_enable), .rx_assembly_start(rx_assembly_start), .rx_clk_sel(rx_clk_sel),
		.rx_clk_ff(rx_clk_ff), .rx_clk_div(rx_clk_div), .tx_rx_clock_out_n(tx_rx_clock_out_n),
		.tx_rx_clock_oe(tx_rx_clock_oe));
	// ------------------------------------------------------------
	// bus and wait tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
		output logic re);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			report_and_stop();
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic re;
		apb(1'b1, a, d, rq, re);
	endtask
	task automatic rd(input logic [7:0] a);
		logic re;
		apb(1'b0, a, 32'h0000_0000, q, re);
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wait_pin(input logic v);
		int n;
		n = 0;
		while (dtr_req_n !== v && n < 30) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("dtr_req_n", v, dtr_req_n)
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, dma_on, slow} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		lvl_n = 3'h7;
		core_lvl = 5'h10;
		clk_src = 4'h0;
		{rx_tx_clk_n, tx_rx_clk_n} = 2'h3;
		err_total = 0;
		checks_done = 0;
		hold(10);
		rst <= 1'b0;
		@(posedge sys_clk);
		`CHK("wait_req_oe", 1'b0, wait_req_oe)
		`CHK("rts_n", 1'b1, rts_n)
		for (int a = 0; a < 5; a++) begin
			rd(8'(a * 4));
			`CHK("ctrl reset", {24'h00_0000, mcp_pkg::RST_CTRL}, q)
		end
		apb(1'b0, 8'h20, 32'h0000_0000, q, e);
		`CHK("unmapped err", 1'b1, e)
		$display("reset test done");
		for (int v = 1; v >= 0; v--) begin
			wr(mcp_pkg::ADDR_TX_CTRL, 32'(v) << mcp_pkg::TXC_RTS | 32'(v) << mcp_pkg::TXC_DTR);
			hold(3);
			`CHK("rts_n", 1'(!v), rts_n)
			`CHK("dtr_req_n", 1'(!v), dtr_req_n)
		end
		$display("outputs test done");
		wr(mcp_pkg::ADDR_RX_CTRL, 32'h0000_0020);
		hold(6);
		`CHK("tx_enable off", 1'b0, tx_enable)
		`CHK("rx_enable off", 1'b0, rx_enable)
		lvl_n <= 3'h1;
		hold(6);
		`CHK("tx_enable on", 1'b1, tx_enable)
		`CHK("rx_enable on", 1'b1, rx_enable)
		wr(mcp_pkg::ADDR_RX_CTRL, 32'h0000_0000);
		lvl_n <= 3'h7;
		hold(6);
		`CHK("tx_enable plain", 1'b1, tx_enable)
		$display("auto enable test done");
		wr(mcp_pkg::ADDR_IRQ_MASK, (32'h0000_0001 << mcp_pkg::IRQ_CTS) | (32'h0000_0001 << mcp_pkg::IRQ_DCD));
		for (int k = 0; k < 4; k++) begin
			wr(mcp_pkg::ADDR_IRQ_STATUS, 32'h0000_000f);
			lvl_n[2 - k % 2] <= !lvl_n[2 - k % 2];
			hold(6);
			rd(mcp_pkg::ADDR_IRQ_STATUS);
			`CHK("edge status", 32'h0000_0001 << ((k % 2 == 1) ? mcp_pkg::IRQ_DCD : mcp_pkg::IRQ_CTS), q)
			`CHK("irq set", 1'b1, irq)
		end
		wr(mcp_pkg::ADDR_IRQ_STATUS, 32'h0000_000f);
		wr(mcp_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		lvl_n[2] <= 1'b0;
		hold(6);
		`CHK("irq masked", 1'b0, irq)
		rd(mcp_pkg::ADDR_IRQ_STATUS);
		`CHK("masked status", 32'h0000_0001 << mcp_pkg::IRQ_CTS, q)
		$display("interrupt test done");
		wr(mcp_pkg::ADDR_MODE_CTRL, 32'h0000_0004);
		lvl_n <= 3'h6;
		hold(6);
		rd(mcp_pkg::ADDR_MAIN_STATUS);
		`CHK("sync status", 1'b1, q[mcp_pkg::ST_SYNC])
		`CHK("sync input", 1'b0, sync_oe)
		wr(mcp_pkg::ADDR_RX_CTRL, 32'h0000_0020);
		for (int m = 0; m < 2; m++) begin
			wr(mcp_pkg::ADDR_MODE_CTRL, m ? 32'h0000_0020 : 32'h0000_0004);
			wr(mcp_pkg::ADDR_EXT_FEAT, 32'(m) << mcp_pkg::EXT_RTS_SDLC);
			core_lvl <= m ? 5'h10 : 5'h00;
			wr(mcp_pkg::ADDR_TX_CTRL, 32'h0000_0002);
			wr(mcp_pkg::ADDR_TX_CTRL, 32'h0000_0000);
			hold(4);
			`CHK("rts_n held", 1'b0, rts_n)
			core_lvl <= m ? 5'h18 : 5'h10;
			hold(5);
			`CHK("rts_n released", 1'b1, rts_n)
		end
		wr(mcp_pkg::ADDR_RX_CTRL, 32'h0000_0000);
		lvl_n <= 3'h7;
		core_lvl <= 5'h14;
		for (int s = 0; s < 4; s++) begin
			wr(mcp_pkg::ADDR_MODE_CTRL, 32'(s) << mcp_pkg::MODE_SYNC_LO);
			hold(2);
			`CHK("sync_oe", 1'(s != 3), sync_oe)
			`CHK("sync_out_n", 1'(s > 1), sync_out_n)
		end
		core_lvl <= 5'h10;
		e = 1'b0;
		lvl_n <= 3'h6;
		repeat (8) begin
			@(posedge sys_clk);
			e = e | rx_assembly_start;
		end
		`CHK("assembly start", 1'b1, e)
		lvl_n <= 3'h7;
		$display("sync pin test done");
		wr(mcp_pkg::ADDR_MISC_CTRL, 32'h0000_0004);
		for (int f = 0; f < 2; f++) begin
			wr(mcp_pkg::ADDR_EXT_FEAT, 32'(f) << mcp_pkg::EXT_DTR_FAST);
			slow <= 1'(f);
			dma_on <= 1'b1;
			wait_pin(1'b0);
			wait_pin(1'b1);
			dma_on <= 1'b0;
			hold(2);
		end
		rd(mcp_pkg::ADDR_IRQ_STATUS);
		`CHK("wait status", 1'b1, q[mcp_pkg::IRQ_W])
		wr(mcp_pkg::ADDR_MISC_CTRL, 32'h0000_0002);
		hold(2);
		`CHK("wait_req_oe", 1'b1, wait_req_oe)
		`CHK("wait_req_out idle", 1'b1, wait_req_out)
		core_lvl <= 5'h11;
		hold(4);
		`CHK("wait_req_out req", 1'b0, wait_req_out)
		core_lvl <= 5'h10;
		$display("request test done");
		for (int c = 0; c < 4; c++) begin
			wr(mcp_pkg::ADDR_MODE_CTRL, 32'(c) << mcp_pkg::MODE_CLK_LO);
			hold(2);
			`CHK("rx_clk_div", (c == 0) ? 7'h01 : 7'(8 << c), rx_clk_div)
		end
		clk_src <= 4'h2;
		wr(mcp_pkg::ADDR_MISC_CTRL, 32'h0000_0031);
		hold(3);
		`CHK("rx_clk_sel", 2'h3, rx_clk_sel)
		`CHK("rx_clk_ff xtal", 1'b1, rx_clk_ff)
		wr(mcp_pkg::ADDR_MISC_CTRL, 32'h0000_0048);
		hold(3);
		`CHK("tx_rx_clock_oe", 1'b1, tx_rx_clock_oe)
		`CHK("tx_rx_clock_out_n src", 1'b0, tx_rx_clock_out_n)
		clk_src <= 4'h0;
		{rx_tx_clk_n, tx_rx_clk_n} <= 2'h0;
		wr(mcp_pkg::ADDR_MISC_CTRL, 32'h0000_0000);
		hold(3);
		`CHK("rx_clk_ff pin", 1'b1, rx_clk_ff)
		`CHK("tx_rx_clock_out_n in", 1'b0, tx_rx_clock_out_n)
		$display("clock pin test done");
		report_and_stop();
	end
endmodule
bind mcp_top mcp_sva u_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq), .modem_in(modem_in),
	.core(core), .rts_n(rts_n), .dtr_req_n(dtr_req_n), .wait_req_oe(wait_req_oe), .tx_enable(tx_enable),
	.rx_enable(rx_enable));
